// *** expbus_chk_sva.sv ***
// concurrent checks on the expansion bus engine ports
// assumes four aclk per bus half, as the package timing gives
`timescale 1ns/1ps
module expbus_chk
	import expbus_pkg::*;
(
	// clock and reset
	input wire logic      aclk,
	input wire logic      aresetn,
	// register read
	input wire logic      s_axi_arvalid,
	input wire logic      s_axi_arready,
	input wire logic      s_axi_rvalid,
	// cpu side and pins
	input wire cpu_req_t  req,
	input wire logic      req_valid,
	input wire logic      req_ready,
	input wire logic      resp_valid,
	input wire exp_pins_t pins
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic take;
	assign take = req_valid && req_ready;
	sequence addr_half;
		pins.address_latch_strobe [*3] ##1 !pins.address_latch_strobe;
	endsequence
	sequence read_half;
		!pins.ad_oe [*4] ##2 resp_valid;
	endsequence
	a_strobe_shape: assert property (req_ready |=> addr_half)
		else $error("latch strobe shape wrong");
	a_strobe_gap: assert property ($fell(pins.address_latch_strobe) |-> ##4 req_ready)
		else $error("data half length wrong");
	a_addr_out: assert property (take |=> pins.ad_oe && pins.ad_out == $past(req.addr[7:0])
		&& pins.addr_hi == $past(req.addr[15:8]))
		else $error("address not on pins");
	a_addr_hold: assert property ($fell(pins.address_latch_strobe) |-> $stable(pins.addr_hi) [*5])
		else $error("high address moved");
	a_wr_data: assert property (take && req.write |-> ##5 pins.ad_oe && pins.ad_out == $past(req.wdata, 5))
		else $error("write data not on pins");
	a_wr_dir: assert property (take && req.write |-> ##5 !pins.rw_or_wr [*4])
		else $error("write line not low");
	a_rd_release: assert property (take && !req.write |-> ##5 read_half)
		else $error("read half wrong");
	a_addr_clk: assert property (pins.address_latch_strobe |-> pins.clk_or_rd)
		else $error("clock or read strobe low in address half");
	a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule

bind multiplexed_expansion_bus expbus_chk u_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .req, .req_valid, .req_ready, .resp_valid, .pins);

// *** expbus_pkg.sv ***
// constants, field layouts and carrier types of the multiplexed expansion bus
// assumes a 100 MHz aclk and a 32-bit AXI4-Lite register port
package expbus_pkg;

	// timing
	localparam int CLK_MHZ       = 100;
	localparam int BUS_HALF_NS   = 40;
	localparam int HALF_CYCLES   = (BUS_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam logic [2:0] HALF_LAST  = 3'(HALF_CYCLES - 1);
	localparam logic [2:0] SYNC_SETTLE = 3'h6;

	// option register fields
	localparam int OPT_STROBE_BIT = 5;
	localparam int OPT_WDOG_BIT   = 2;
	localparam int OPT_RAM_BIT    = 1;
	localparam logic [7:0] OPT_IMPL_MASK = 8'h26;
	localparam logic [7:0] OPT_RESET     = 8'h00;

	// status register fields
	localparam int ST_SPECIAL_BIT = 0;
	localparam int ST_WRITTEN_BIT = 1;
	localparam int ST_PENDING_BIT = 2;
	localparam int ST_BUSY_BIT    = 3;

	// register byte offsets
	localparam logic [3:0] OFF_OPTION = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// memory map
	localparam logic [15:0] RAM_BASE    = 16'h0400;
	localparam logic [15:0] RAM_TOP     = 16'h04ff;
	localparam logic [15:0] VECTOR_BASE = 16'hffc0;

	typedef enum logic {
		PH_ADDR = 1'b0,
		PH_DATA = 1'b1
	} phase_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        write;
		logic [7:0]  wdata;
	} cpu_req_t;

	typedef struct packed {
		logic [7:0] addr_hi;
		logic [7:0] ad_out;
		logic       ad_oe;
		logic       address_latch_strobe;
		logic       clk_or_rd;
		logic       rw_or_wr;
	} exp_pins_t;

endpackage

// *** ext_mem.sv ***
// external memory behind a transparent address latch
// assumes the bench tells it the active strobe mode
`timescale 1ns/1ps
module ext_mem
	import expbus_pkg::*;
(
	// clock
	input  wire logic      aclk,
	// bus pins
	input  wire exp_pins_t pins,
	input  wire logic      strobe_mode,
	output logic [7:0]     ad_in
);
	logic [7:0] mem [0:65535];
	logic [7:0] lat;
	logic [7:0] last = 8'h5a;
	logic       we_n;
	logic       rd;
	always_latch begin
		if (pins.address_latch_strobe)
			lat <= pins.ad_out;
	end
	assign we_n = strobe_mode ? pins.rw_or_wr : ~(~pins.clk_or_rd & ~pins.rw_or_wr);
	assign rd = !pins.address_latch_strobe && !pins.clk_or_rd && (strobe_mode || pins.rw_or_wr);
	// released lines show the inverse of the last value
	assign ad_in = rd ? mem[{pins.addr_hi, lat}] : ~last;
	always @(posedge aclk) begin
		if (!we_n)
			mem[{pins.addr_hi, lat}] <= pins.ad_out;
		if (rd)
			last <= ad_in;
	end
endmodule

// *** multiplexed_expansion_bus.sv ***
// expanded-mode bus engine: multiplexed address/data pins, latch strobe,
// inverted bus clock or read/write strobes, option register over axi4-lite
// assumes an external transparent latch and a cpu issuing one byte per bus cycle
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module multiplexed_expansion_bus
	import expbus_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// cpu side
	input  wire cpu_req_t    req,
	input  wire logic        req_valid,
	output logic             req_ready,
	output logic             resp_valid,
	output logic [7:0]       resp_rdata,
	input  wire logic        instr_start,
	// device pins
	output exp_pins_t        pins,
	input  wire logic [7:0]  ad_in,
	input  wire logic        mode_select_pin,
	// option outputs
	output logic             watchdog_disable
);
	logic [7:0] ram [0:255];

	// synchronised pins
	logic       mode_s;
	logic [7:0] ad_s;
	pin_sync3 #(.W(1)) u_mode_sync (.aclk(aclk), .aresetn(aresetn),
		.d(mode_select_pin), .q(mode_s));
	pin_sync3 #(.W(8)) u_ad_sync (.aclk(aclk), .aresetn(aresetn),
		.d(ad_in), .q(ad_s));
	// internal decode: ram hit, never for vectors
	function automatic logic is_internal(input logic [15:0] a, input logic ram_en);
		is_internal = ram_en && (a >= RAM_BASE) && (a <= RAM_TOP) && (a < VECTOR_BASE);
	endfunction
	// mode capture and option state
	logic [2:0]  cap_cnt, next_cap_cnt;
	logic        special_mode_flag, next_special, pending, next_pending;
	logic        written_once, next_written_once;
	logic [7:0]  opt_active, next_opt_active, opt_pending, next_opt_pending;
	// axi state
	logic        aw_held, next_aw_held, w_held, next_w_held, w_strb0, next_w_strb0;
	logic        next_bvalid, next_rvalid, do_write, opt_write;
	logic [3:0]  aw_addr, next_aw_addr;
	logic [7:0]  w_byte, next_w_byte;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	// bus engine state
	phase_t      phase, next_phase;
	logic [2:0]  cnt, next_cnt;
	cpu_req_t    cur, next_cur;
	logic        cur_valid, next_cur_valid, cur_int, next_cur_int;
	logic        next_resp_valid, cycle_end, ram_we;
	logic        n_rd_n, n_wr_n, n_clk_n, n_rw;
	logic        rd_wait, next_rd_wait, rd_int, next_rd_int;
	logic [7:0]  next_resp_rdata;
	exp_pins_t   next_pins;
	assign s_axi_awready    = !aw_held && !s_axi_bvalid;
	assign s_axi_wready     = !w_held && !s_axi_bvalid;
	assign s_axi_arready    = !s_axi_rvalid;
	assign watchdog_disable = opt_active[OPT_WDOG_BIT];

	// register access
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_byte  = w_byte;
		next_w_strb0 = w_strb0;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		next_rvalid  = s_axi_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held  = 1'b1;
			next_w_byte  = s_axi_wdata[7:0];
			next_w_strb0 = s_axi_wstrb[0];
		end
		do_write  = aw_held && w_held && !s_axi_bvalid;
		opt_write = 1'b0;
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			if (aw_addr == OFF_OPTION) begin
				next_bresp = RESP_OKAY;
				opt_write  = w_strb0 && (special_mode_flag || !written_once);
			end else if (aw_addr == OFF_STATUS) begin
				next_bresp = RESP_OKAY;
			end else begin
				next_bresp = RESP_SLVERR;
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			if (s_axi_araddr == OFF_OPTION) begin
				next_rdata = {24'h000000, opt_active & OPT_IMPL_MASK};
			end else if (s_axi_araddr == OFF_STATUS) begin
				next_rdata = 32'h00000000;
				next_rdata[ST_SPECIAL_BIT] = special_mode_flag;
				next_rdata[ST_WRITTEN_BIT] = written_once;
				next_rdata[ST_PENDING_BIT] = pending;
				next_rdata[ST_BUSY_BIT]    = cur_valid;
			end else begin
				next_rdata = 32'h00000000;
				next_rresp = RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// option register and mode flag
	always_comb begin
		next_cap_cnt      = cap_cnt;
		next_special      = special_mode_flag;
		next_opt_active   = opt_active;
		next_opt_pending  = opt_pending;
		next_pending      = pending;
		next_written_once = written_once;
		if (cap_cnt != SYNC_SETTLE) begin
			next_cap_cnt = cap_cnt + 3'h1;
			next_special = !mode_s;
		end
		if (instr_start && pending) begin
			next_opt_active = opt_pending;
			next_pending    = 1'b0;
		end
		if (opt_write) begin
			next_opt_pending  = w_byte & OPT_IMPL_MASK;
			next_pending      = 1'b1;
			next_written_once = 1'b1;
		end
	end

	// bus cycle sequencing
	always_comb begin
		cycle_end       = (phase == PH_DATA) && (cnt == HALF_LAST);
		req_ready       = cycle_end;
		next_phase      = phase;
		next_cnt        = cnt + 3'h1;
		next_cur        = cur;
		next_cur_valid  = cur_valid;
		next_cur_int    = cur_int;
		next_resp_valid = 1'b0;
		next_resp_rdata = resp_rdata;
		next_rd_wait    = 1'b0;
		next_rd_int     = rd_int;
		ram_we          = 1'b0;
		// synchronised pins settle one edge after the data half ends
		if (rd_wait) begin
			next_resp_valid = 1'b1;
			next_resp_rdata = rd_int ? resp_rdata : ad_s;
		end
		if (cnt == HALF_LAST) begin
			next_cnt   = 3'h0;
			next_phase = (phase == PH_ADDR) ? PH_DATA : PH_ADDR;
		end
		if (cycle_end) begin
			if (cur_valid && !cur.write) begin
				next_rd_wait    = 1'b1;
				next_rd_int     = cur_int;
				next_resp_rdata = cur_int ? ram[cur.addr[7:0]] : resp_rdata;
			end
			ram_we = cur_valid && cur.write && cur_int;
			if (req_valid) begin
				next_cur       = req;
				next_cur_valid = 1'b1;
				// internal only when ram is enabled; vectors stay external
				next_cur_int   = is_internal(req.addr, opt_active[OPT_RAM_BIT]);
			end else begin
				// idle cycle keeps the bus running on the last address, as a read only in clock mode (no read strobe in strobe mode)
				next_cur_valid = 1'b0;
				next_cur.write = 1'b0;
				next_cur_int   = 1'b0;
			end
		end
	end

	// pin drive, computed from next state
	always_comb begin
		next_pins         = pins;
		next_pins.addr_hi = next_cur.addr[15:8];
		n_clk_n = (next_phase == PH_ADDR);
		n_rw    = !(next_cur_valid && next_cur.write);
		n_rd_n  = !((next_phase == PH_DATA) && next_cur_valid && !next_cur.write
			&& !next_cur_int);
		n_wr_n  = !((next_phase == PH_DATA) && next_cur_valid && next_cur.write);
		next_pins.address_latch_strobe = (next_phase == PH_ADDR) && (next_cnt != HALF_LAST);
		if (next_phase == PH_ADDR) begin
			next_pins.ad_out = next_cur.addr[7:0];
			next_pins.ad_oe  = 1'b1;
		end else begin
			next_pins.ad_out = next_cur.wdata;
			next_pins.ad_oe  = next_cur_valid && next_cur.write;
		end
		if (opt_active[OPT_STROBE_BIT]) begin
			next_pins.clk_or_rd = n_rd_n;
			next_pins.rw_or_wr  = n_wr_n;
		end else begin
			next_pins.clk_or_rd = n_clk_n;
			next_pins.rw_or_wr  = n_rw;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 4'h0;
			w_byte       <= 8'h00;
			w_strb0      <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OKAY;
		end else begin
			aw_held      <= next_aw_held;
			w_held       <= next_w_held;
			aw_addr      <= next_aw_addr;
			w_byte       <= next_w_byte;
			w_strb0      <= next_w_strb0;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rresp;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_cnt           <= 3'h0;
			special_mode_flag <= 1'b0;
			opt_active        <= OPT_RESET;
			opt_pending       <= OPT_RESET;
			pending           <= 1'b0;
			written_once      <= 1'b0;
		end else begin
			cap_cnt           <= next_cap_cnt;
			special_mode_flag <= next_special;
			opt_active        <= next_opt_active;
			opt_pending       <= next_opt_pending;
			pending           <= next_pending;
			written_once      <= next_written_once;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase      <= PH_ADDR;
			cnt        <= 3'h0;
			cur        <= '0;
			cur_valid  <= 1'b0;
			cur_int    <= 1'b0;
			resp_valid <= 1'b0;
			resp_rdata <= 8'h00;
			rd_wait    <= 1'b0;
			rd_int     <= 1'b0;
			pins       <= '{addr_hi: 8'h00, ad_out: 8'h00, ad_oe: 1'b1,
				address_latch_strobe: 1'b1, clk_or_rd: 1'b1, rw_or_wr: 1'b1};
		end else begin
			phase      <= next_phase;
			cnt        <= next_cnt;
			cur        <= next_cur;
			cur_valid  <= next_cur_valid;
			cur_int    <= next_cur_int;
			resp_valid <= next_resp_valid;
			resp_rdata <= next_resp_rdata;
			rd_wait    <= next_rd_wait;
			rd_int     <= next_rd_int;
			pins       <= next_pins;
		end
	end

	// internal ram
	always_ff @(posedge aclk) begin
		if (ram_we) begin
			ram[cur.addr[7:0]] <= cur.wdata;
		end
	end
endmodule

// *** pin_sync3.sv ***
// three-flop input synchroniser with agreement filter
// assumes d is asynchronous to aclk
`timescale 1ns/1ps
module pin_sync3 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// pin side
	input  wire logic [W-1:0] d,
	// synchronised value
	output logic      [W-1:0] q
);
	logic [W-1:0] f1;
	logic [W-1:0] f2;
	logic [W-1:0] f3;
	logic [W-1:0] next_q;

	// change accepted once second and third stage agree
	always_comb begin
		next_q = (f2 == f3) ? f3 : q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			f1 <= '0;
			f2 <= '0;
			f3 <= '0;
			q  <= '0;
		end else begin
			f1 <= d;
			f2 <= f1;
			f3 <= f2;
			q  <= next_q;
		end
	end
endmodule

// *** tb.sv ***
// self-checking bench for the expansion bus engine
// assumes ext_mem on the pins and the hand-over timing of the design
`timescale 1ns/1ps
module tb
	import expbus_pkg::*;
;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, req_valid, req_ready, resp_valid, instr_start;
	logic        mode_select_pin, watchdog_disable, smode, watch;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [7:0]  resp_rdata, ad_in, rd;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	cpu_req_t    req;
	exp_pins_t   pins;
	int          err_count, comparisons, cycles, dir_hi;

	multiplexed_expansion_bus uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .req, .req_valid, .req_ready, .resp_valid, .resp_rdata,
		.instr_start, .pins, .ad_in, .mode_select_pin, .watchdog_disable);
	ext_mem u_mem (.aclk, .pins, .strobe_mode(smode), .ad_in);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
		logic aw_t, w_t, b_t;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b_t = 1'b0;
		for (int n = 0; n < 50 && !b_t; n++) begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw_t)
				s_axi_awvalid <= 1'b0;
			if (w_t)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk({b_t, r}, {1'b1, RESP_OKAY});
	endtask

	task automatic axi_rd(input logic [3:0] a);
		logic a_t, r_t;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		r_t = 1'b0;
		for (int n = 0; n < 50 && !r_t; n++) begin
			@(negedge aclk);
			a_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (a_t)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk(r_t, 1'b1);
	endtask

	task automatic bus_op(input logic [15:0] a, input logic wr, input logic [7:0] wd, input logic ext);
		logic t;
		@(posedge aclk);
		req <= '{addr: a, write: wr, wdata: wd};
		req_valid <= 1'b1;
		t = 1'b0;
		for (int n = 0; n < 20 && !t; n++) begin
			@(negedge aclk);
			t = req_ready;
			@(posedge aclk);
		end
		req_valid <= 1'b0;
		@(negedge aclk);
		chk({t, pins.addr_hi, pins.ad_out, pins.ad_oe, pins.address_latch_strobe, pins.clk_or_rd},
			{1'b1, a, 3'h7});
		chk(pins.rw_or_wr, smode | !wr);
		repeat (3) @(negedge aclk);
		chk(pins.address_latch_strobe, 1'b0);
		@(negedge aclk);
		chk({pins.ad_oe, pins.clk_or_rd, pins.rw_or_wr}, {wr, smode & (wr | !ext), !wr});
		if (wr)
			chk(pins.ad_out, wd);
		for (int n = 0; n < 20 && !wr && !resp_valid; n++)
			@(negedge aclk);
		chk(resp_valid, !wr);
		rd = resp_rdata;
	endtask

	task automatic ipulse;
		@(posedge aclk);
		instr_start <= 1'b1;
		@(posedge aclk);
		instr_start <= 1'b0;
	endtask

	task automatic do_reset(input int cyc);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (cyc) @(posedge aclk);
		aresetn <= 1'b1;
		smode <= 1'b0;
		repeat (10) @(posedge aclk);
	endtask

	task automatic t_reset_vals;
		axi_rd(OFF_OPTION);
		chk(d, OPT_RESET);
		axi_rd(OFF_STATUS);
		chk(d[ST_SPECIAL_BIT], 1'b0);
		axi_rd(4'h8);
		chk({d, r}, {32'h0, RESP_SLVERR});
	endtask

	task automatic t_mode0;
		bus_op(16'h1234, 1'b1, 8'ha5, 1'b1);
		watch = 1'b1;
		bus_op(16'h1235, 1'b1, 8'h5a, 1'b1);
		watch = 1'b0;
		chk(dir_hi, 0);
		bus_op(16'hffc0, 1'b1, 8'hc3, 1'b1);
		bus_op(16'h0400, 1'b1, 8'h77, 1'b1);
		bus_op(16'h1234, 1'b0, 8'h00, 1'b1);
		chk(rd, 8'ha5);
		bus_op(16'h0400, 1'b0, 8'h00, 1'b1);
		chk(rd, 8'h77);
	endtask

	task automatic t_option;
		axi_wr(OFF_OPTION, 32'hff);
		axi_rd(OFF_STATUS);
		chk(d[ST_PENDING_BIT], 1'b1);
		axi_rd(OFF_OPTION);
		chk(d, OPT_RESET);
		bus_op(16'h1235, 1'b0, 8'h00, 1'b1);
		chk(rd, 8'h5a);
		ipulse;
		smode <= 1'b1;
		axi_rd(OFF_OPTION);
		chk({watchdog_disable, d}, {1'b1, 32'h26});
		axi_wr(OFF_OPTION, 32'h00);
		ipulse;
		axi_rd(OFF_OPTION);
		chk(d, 32'h26);
	endtask

	task automatic t_mode1;
		bus_op(16'h2345, 1'b1, 8'h96, 1'b1);
		bus_op(16'h2345, 1'b0, 8'h00, 1'b1);
		chk(rd, 8'h96);
		bus_op(16'h0400, 1'b1, 8'h3c, 1'b0);
		bus_op(16'h0400, 1'b0, 8'h00, 1'b0);
		chk(rd, 8'h3c);
		bus_op(16'hffc0, 1'b0, 8'h00, 1'b1);
		chk(rd, 8'hc3);
	endtask

	task automatic t_special;
		mode_select_pin <= 1'b0;
		repeat (4) @(posedge aclk);
		do_reset(4);
		axi_rd(OFF_STATUS);
		chk(d[ST_SPECIAL_BIT], 1'b1);
		axi_wr(OFF_OPTION, 32'h20);
		ipulse;
		axi_wr(OFF_OPTION, 32'h02);
		ipulse;
		axi_rd(OFF_OPTION);
		chk(d, 32'h02);
	endtask

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cycles++;
		if (watch && pins.rw_or_wr)
			dir_hi++;
		if (cycles == 5000) begin
			err_count++;
			test_done;
		end
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{req_valid, instr_start, smode, watch, s_axi_awaddr, s_axi_wstrb, s_axi_araddr} = '0;
		{s_axi_wdata, req} = '0;
		mode_select_pin = 1'b1;
		do_reset(2);
		t_reset_vals;
		t_mode0;
		t_option;
		t_mode1;
		t_special;
		test_done;
	end
endmodule
